// ---- wdr_pkg.sv ----
// Package: constants, pin groups and the state record of the watchdog
// and reset-cause block.
// Assumes a 10 MHz pclk and an APB master with 32-bit data.
`default_nettype none

package wdr_pkg;

  // ***************************
  // Register map
  // ***************************
  localparam logic [7:0] OFS_CAUSE = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;

  // Reset-cause bit positions
  localparam int CAUSE_SCAN = 4;
  localparam int CAUSE_DOG = 3;
  localparam int CAUSE_DROP = 2;
  localparam int CAUSE_PIN = 1;
  localparam int CAUSE_POWER = 0;
  localparam logic [4:0] CAUSE_RESET = 5'h01;

  // Control bit positions
  localparam int CTRL_IRQ_FLAG = 7;
  localparam int CTRL_IRQ_EN = 6;
  localparam int CTRL_PRESC_HI = 5;
  localparam int CTRL_CHG_EN = 4;
  localparam int CTRL_RST_EN = 3;

  localparam logic [2:0] DROP_OFF_CODE = 3'h7;
  localparam logic [3:0] PRESC_MAX_CODE = 4'h9;

  // ***************************
  // Timing
  // ***************************
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int DOG_OSC_HZ = 128_000;
  localparam int TICK_DIV = SYS_CLK_HZ / DOG_OSC_HZ;
  localparam int STARTUP_US = 65;
  localparam int STARTUP_CYC = STARTUP_US * (SYS_CLK_HZ / 1_000_000);
  localparam int CHG_WINDOW_CYC = 4;

  // ***************************
  // Carriers
  // ***************************
  typedef struct packed {
    logic pin_reset_n;
    logic supply_below;
    logic scan_reset_bit;
  } wdr_pins_t;

  typedef struct packed {
    logic always_on_fuse;
    logic [2:0] supply_drop_level_fuses;
  } wdr_fuses_t;

  typedef struct packed {
    wdr_pins_t pins_s1;
    wdr_pins_t pins_s2;
    wdr_fuses_t fuse_s1;
    wdr_fuses_t fuse_s2;
    logic [6:0] div;
    logic tick;
    logic [20:0] cnt;
    logic [4:0] cause;
    logic irq_flag;
    logic irq_en;
    logic chg_en;
    logic [2:0] chg_cnt;
    logic rst_en;
    logic [3:0] presc;
    logic dog_pulse;
    logic chip_reset;
    logic [9:0] delay;
    logic irq_out;
    logic drop_enable;
    logic [2:0] drop_level;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } wdr_state_t;

endpackage : wdr_pkg

`default_nettype wire

// ---- wdr_watchdog_reset.sv ----
// Watchdog timer and reset-cause status with an APB register slave.
// Assumes pclk at 10 MHz, presetn as the power-on reset, and pins,
// fuses and the scan reset bit arriving from outside the pclk domain.
`default_nettype none

module wdr_watchdog_reset #(
  parameter int unsigned TIMEOUT_BASE = 2048
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire wdr_pkg::wdr_pins_t reset_pins,
  input wire wdr_pkg::wdr_fuses_t fuses,
  input wire logic dog_restart,
  input wire logic dog_irq_ack,
  output logic chip_reset_q,
  output logic dog_irq_q,
  output logic dog_reset_pulse_q,
  output logic supply_drop_enable_q,
  output logic [2:0] supply_drop_level_q
);

  // ***************************
  // State
  // ***************************
  wdr_pkg::wdr_state_t st_q;
  wdr_pkg::wdr_state_t st_d;

  logic aon;
  logic drop_on;
  logic drop_act;
  logic pin_act;
  logic scan_act;
  logic rst_en_eff;
  logic irq_en_eff;
  logic running;
  logic setup;
  logic wr;
  logic wr_cause;
  logic wr_ctrl;
  logic mapped;
  logic src_act;
  logic [3:0] code;
  logic [20:0] lim;
  logic [7:0] ctrl_rd;
  logic [7:0] wd;

  // ***************************
  // Decoded levels
  // ***************************
  // All decoding reads second sync stage only
  assign aon = st_q.fuse_s2.always_on_fuse;
  assign drop_on = st_q.fuse_s2.supply_drop_level_fuses
    != wdr_pkg::DROP_OFF_CODE;
  assign drop_act = drop_on & st_q.pins_s2.supply_below;
  assign pin_act = ~st_q.pins_s2.pin_reset_n;
  assign scan_act = st_q.pins_s2.scan_reset_bit;
  assign src_act = pin_act | drop_act | scan_act | st_q.dog_pulse;

  // Flag forces reset enable, fuse forces mode
  assign rst_en_eff = st_q.rst_en | st_q.cause[wdr_pkg::CAUSE_DOG]
    | aon;
  assign irq_en_eff = st_q.irq_en & ~aon;
  assign running = rst_en_eff | irq_en_eff;

  // Reserved codes run at the longest time-out
  assign code = (st_q.presc > wdr_pkg::PRESC_MAX_CODE)
    ? wdr_pkg::PRESC_MAX_CODE : st_q.presc;
  assign lim = 21'(TIMEOUT_BASE) << code;

  // ***************************
  // Bus decode
  // ***************************
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & st_q.pready;
  assign mapped = (paddr == wdr_pkg::OFS_CAUSE)
    | (paddr == wdr_pkg::OFS_CTRL)
    | (paddr == wdr_pkg::OFS_COUNT);
  assign wr_cause = wr & (paddr == wdr_pkg::OFS_CAUSE);
  assign wr_ctrl = wr & (paddr == wdr_pkg::OFS_CTRL);
  assign wd = pwdata[7:0];

  assign ctrl_rd = {st_q.irq_flag,
                    irq_en_eff,
                    st_q.presc[3],
                    st_q.chg_en,
                    rst_en_eff,
                    st_q.presc[2:0]};

  // ***************************
  // Next state
  // ***************************
  always_comb begin
    st_d = st_q;

    // Two-stage synchronisers
    st_d.pins_s1 = reset_pins;
    st_d.pins_s2 = st_q.pins_s1;
    st_d.fuse_s1 = fuses;
    st_d.fuse_s2 = st_q.fuse_s1;

    // Threshold selection to the analog comparator
    st_d.drop_level = st_q.fuse_s2.supply_drop_level_fuses;
    st_d.drop_enable = drop_on;

    // Oscillator tick from a divider, one pclk wide
    if (st_q.div == 7'(wdr_pkg::TICK_DIV - 1)) begin
      st_d.div = 7'h00;
      st_d.tick = 1'b1;
    end else begin
      st_d.div = st_q.div + 7'h01;
      st_d.tick = 1'b0;
    end

    // APB: zero-wait answer prepared in the setup cycle
    st_d.pready = setup;
    st_d.pslverr = setup & ~mapped;
    if (setup) begin
      st_d.prdata = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          wdr_pkg::OFS_CAUSE: begin
            st_d.prdata = {27'h0000000, st_q.cause};
          end
          wdr_pkg::OFS_CTRL: begin
            st_d.prdata = {24'h000000, ctrl_rd};
          end
          wdr_pkg::OFS_COUNT: begin
            st_d.prdata = {11'h000, st_q.cnt};
          end
          default: begin
            st_d.prdata = 32'h0000_0000;
          end
        endcase
      end
    end

    // Cause flags: zero write clears, event set wins
    if (wr_cause) begin
      st_d.cause = st_q.cause & wd[4:0];
    end
    if (scan_act) begin
      st_d.cause[wdr_pkg::CAUSE_SCAN] = 1'b1;
    end
    if (st_q.dog_pulse) begin
      st_d.cause[wdr_pkg::CAUSE_DOG] = 1'b1;
    end
    if (drop_act) begin
      st_d.cause[wdr_pkg::CAUSE_DROP] = 1'b1;
    end
    if (pin_act) begin
      st_d.cause[wdr_pkg::CAUSE_PIN] = 1'b1;
    end

    // Change window closes by itself
    if (st_q.chg_en) begin
      if (st_q.chg_cnt == 3'(wdr_pkg::CHG_WINDOW_CYC - 1)) begin
        st_d.chg_en = 1'b0;
        st_d.chg_cnt = 3'h0;
      end else begin
        st_d.chg_cnt = st_q.chg_cnt + 3'h1;
      end
    end

    // Control writes
    if (wr_ctrl) begin
      if (wd[wdr_pkg::CTRL_IRQ_FLAG]) begin
        st_d.irq_flag = 1'b0;
      end
      st_d.irq_en = wd[wdr_pkg::CTRL_IRQ_EN] & ~aon;
      if (wd[wdr_pkg::CTRL_CHG_EN] & wd[wdr_pkg::CTRL_RST_EN]) begin
        // Unlock opens a fresh window
        st_d.chg_en = 1'b1;
        st_d.chg_cnt = 3'h0;
        st_d.rst_en = 1'b1;
      end else if (st_q.chg_en) begin
        // Prescaler changes and reset-enable clears only happen inside the window
        st_d.rst_en = wd[wdr_pkg::CTRL_RST_EN]
          | st_q.cause[wdr_pkg::CAUSE_DOG];
        st_d.presc = {wd[wdr_pkg::CTRL_PRESC_HI], wd[2:0]};
        st_d.chg_en = 1'b0;
        st_d.chg_cnt = 3'h0;
      end else begin
        // Setting is always allowed, clearing is not
        st_d.rst_en = st_q.rst_en | wd[wdr_pkg::CTRL_RST_EN];
        if (wd[wdr_pkg::CTRL_CHG_EN]) begin
          st_d.chg_en = 1'b1;
          st_d.chg_cnt = 3'h0;
        end
      end
    end

    // Vector taken: leaves combined mode for reset mode
    if (dog_irq_ack) begin
      st_d.irq_flag = 1'b0;
      if (rst_en_eff) begin
        st_d.irq_en = 1'b0;
      end
    end

    // Watchdog counter
    st_d.dog_pulse = 1'b0;
    if (dog_restart || !running) begin
      st_d.cnt = 21'h000000;
    end else if (st_q.tick) begin
      if (st_q.cnt == lim - 21'h000001) begin
        st_d.cnt = 21'h000000;
        if (irq_en_eff && !rst_en_eff) begin
          st_d.irq_flag = 1'b1;
        end else if (irq_en_eff && !st_q.irq_flag) begin
          st_d.irq_flag = 1'b1;
        end else begin
          st_d.dog_pulse = 1'b1;
        end
      end else begin
        st_d.cnt = st_q.cnt + 21'h000001;
      end
    end

    // Reset stretch: any source holds, delay after the last one ends
    if (src_act) begin
      st_d.chip_reset = 1'b1;
      st_d.delay = 10'h000;
    end else if (st_q.chip_reset) begin
      if (st_q.delay == 10'(wdr_pkg::STARTUP_CYC - 1)) begin
        st_d.chip_reset = 1'b0;
      end else begin
        st_d.delay = st_q.delay + 10'h001;
      end
    end

    // Chip reset returns watchdog control to defaults.
    // Cause flags survive so software can read them afterwards.
    if (st_q.chip_reset) begin
      st_d.irq_flag = 1'b0;
      st_d.irq_en = 1'b0;
      st_d.chg_en = 1'b0;
      st_d.chg_cnt = 3'h0;
      st_d.rst_en = 1'b0;
      st_d.presc = 4'h0;
      st_d.cnt = 21'h000000;
    end

    // Interrupt line, also the wake request in sleep
    st_d.irq_out = st_d.irq_flag & st_d.irq_en & ~aon;
  end

  // ***************************
  // Registers
  // ***************************
  // Power-up flag is the only cause set by the async reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{pins_s1: '{pin_reset_n: 1'b1, default: 1'b0},
                pins_s2: '{pin_reset_n: 1'b1, default: 1'b0},
                cause: wdr_pkg::CAUSE_RESET,
                chip_reset: 1'b1,
                default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // ***************************
  // Outputs
  // ***************************
  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign chip_reset_q = st_q.chip_reset;
  assign dog_irq_q = st_q.irq_out;
  assign dog_reset_pulse_q = st_q.dog_pulse;
  assign supply_drop_enable_q = st_q.drop_enable;
  assign supply_drop_level_q = st_q.drop_level;

endmodule : wdr_watchdog_reset

`default_nettype wire

// ---- wdr_checker.sv ----
// Checker: bus timing, reset paths and watchdog pulse properties.
// Assumes a bind onto wdr_watchdog_reset with presetn active low.
`default_nettype none
// ***
// Checker
// ***
module wdr_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire wdr_pkg::wdr_pins_t reset_pins,
  input wire logic chip_reset_q,
  input wire logic dog_reset_pulse_q,
  input wire logic supply_drop_enable_q,
  input wire logic [2:0] supply_drop_level_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_once;
    !dog_reset_pulse_q;
  endsequence
  sequence s_hold;
    chip_reset_q [*8];
  endsequence
  a_pulse_short: assert property (dog_reset_pulse_q |=> s_once)
    else $error("watchdog pulse too long");
  a_pulse_stretch: assert property (dog_reset_pulse_q |=> s_hold)
    else $error("watchdog pulse without chip reset");
  // Only checked out of reset, while the fuse copy has settled
  a_drop_code: assert property (!chip_reset_q |->
    supply_drop_enable_q == (supply_drop_level_q != 3'h7))
    else $error("drop enable wrong for level");
  a_pin_path: assert property (!reset_pins.pin_reset_n |-> ##[1:4] chip_reset_q)
    else $error("pin reset not applied");
  a_drop_path: assert property (reset_pins.supply_below && supply_drop_enable_q
    |-> ##[1:4] chip_reset_q)
    else $error("drop reset not applied");
  a_scan_path: assert property (reset_pins.scan_reset_bit |-> ##[1:4] chip_reset_q)
    else $error("scan reset not applied");
  a_ready_access: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  a_ready_idle: assert property (!psel |=> !pready)
    else $error("ready without request");
  a_err_unmapped: assert property (psel && penable && paddr > 8'h08 |-> pslverr)
    else $error("unmapped access not flagged");
endmodule : wdr_checker
bind wdr_watchdog_reset wdr_checker u_chk (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .reset_pins, .chip_reset_q, .dog_reset_pulse_q,
  .supply_drop_enable_q, .supply_drop_level_q);
`default_nettype wire

// ---- wdr_core_model.sv ----
// Partner: processor core issuing restarts and taking the vector.
// Assumes pclk; ack_wait of zero means the vector never runs.
`default_nettype none
module wdr_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dog_irq_q,
  input wire logic kick,
  input wire logic [3:0] ack_wait,
  output logic dog_restart,
  output logic dog_irq_ack
);
  // ***
  // Core
  // ***
  logic [3:0] wait_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dog_restart <= 1'b0;
      dog_irq_ack <= 1'b0;
      wait_q <= 4'h0;
    end else begin
      dog_restart <= kick;
      dog_irq_ack <= dog_irq_q && ack_wait != 4'h0 && wait_q == ack_wait;
      wait_q <= dog_irq_q ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule : wdr_core_model
`default_nettype wire

// ---- test_wdr_watchdog_reset.sv ----
// Testbench: reset sources, cause flags and watchdog modes.
// Assumes package, design, core model and checker compiled first.
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_wdr_watchdog_reset;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic kick = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] ack_wait = 4'h0;
  wdr_pkg::wdr_pins_t pins = 3'b100;
  wdr_pkg::wdr_fuses_t fuses = 4'h6;
  logic pready, pslverr, er, chip_rst, irq, pulse, den, dog_restart, dog_irq_ack;
  logic [31:0] prdata, rd, seed, ex;
  logic [2:0] lvl;
  int bad_count = 0, cmp_count = 0, cyc = 0, n;
  // Short base keeps time-outs to a few hundred cycles
  wdr_watchdog_reset #(.TIMEOUT_BASE(4)) uut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_pins(pins),
    .fuses, .dog_restart, .dog_irq_ack, .chip_reset_q(chip_rst), .dog_irq_q(irq),
    .dog_reset_pulse_q(pulse), .supply_drop_enable_q(den), .supply_drop_level_q(lvl));
  wdr_core_model core (.pclk, .presetn, .dog_irq_q(irq), .kick, .ack_wait,
    .dog_restart, .dog_irq_ack);
  // ***
  // Helpers
  // ***
  initial begin
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Mismatches %0d of %0d compares", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rchk
  task automatic settle();
    repeat (4) @(posedge pclk);
    while (chip_rst !== 1'b0) @(posedge pclk);
  endtask : settle
  task automatic hit(input int k);
    pins <= 3'b100 ^ (3'b100 >> k);
    repeat (4) @(posedge pclk);
    pins <= 3'b100;
    settle();
  endtask : hit
  task automatic tap();
    kick <= 1'b1;
    @(posedge pclk);
    kick <= 1'b0;
  endtask : tap
  task automatic setctl(input logic [7:0] v);
    bus(1'b1, 8'h04, 32'h18);
    bus(1'b1, 8'h04, {24'h0, v});
  endtask : setctl
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // ***
  // Scenarios
  // ***
  initial begin
    seed = 32'hcef5;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    rchk(8'h00, 32'h01);
    `CHK(er, 1'b0)
    `CHK(lvl, 3'h6)
    `CHK(den, 1'b1)
    bus(1'b0, 8'h0c, 32'h0);
    `CHK(er, 1'b1)
    hit(0);
    rchk(8'h00, 32'h03);
    hit(1);
    rchk(8'h00, 32'h07);
    hit(2);
    rchk(8'h00, 32'h17);
    fuses.supply_drop_level_fuses <= 3'h7;
    repeat (6) @(posedge pclk);
    `CHK(den, 1'b0)
    `CHK(lvl, 3'h7)
    pins.supply_below <= 1'b1;
    repeat (6) @(posedge pclk);
    `CHK(chip_rst, 1'b0)
    pins.supply_below <= 1'b0;
    fuses.supply_drop_level_fuses <= 3'h6;
    ex = 32'h17;
    // Zeros clear a flag, ones never set one
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      ex = ex & seed;
      bus(1'b1, 8'h00, seed);
      rchk(8'h00, ex);
    end
    bus(1'b1, 8'h00, 32'h0);
    setctl(8'h41);
    for (int i = 0; i < 2; i++) begin
      repeat (400) @(posedge pclk);
      tap();
      `CHK(irq, 1'b0)
    end
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
    `CHK(n > 7 * wdr_pkg::TICK_DIV && n < 9 * wdr_pkg::TICK_DIV, 1'b1)
    bus(1'b1, 8'h04, 32'h80);
    ack_wait <= 4'h9;
    bus(1'b1, 8'h04, 32'h48);
    tap();
    wait (irq === 1'b1);
    wait (irq === 1'b0);
    rchk(8'h04, 32'h09);
    wait (pulse === 1'b1);
    settle();
    tap();
    rchk(8'h00, 32'h08);
    rchk(8'h04, 32'h08);
    setctl(8'h00);
    rchk(8'h04, 32'h08);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h04, 32'h18);
    repeat (5) @(posedge pclk);
    bus(1'b1, 8'h04, 32'h00);
    rchk(8'h04, 32'h08);
    setctl(8'h00);
    rchk(8'h04, 32'h00);
    fuses.always_on_fuse <= 1'b1;
    repeat (6) @(posedge pclk);
    bus(1'b1, 8'h04, 32'h40);
    rchk(8'h04, 32'h08);
    complete_run();
  end
endmodule : test_wdr_watchdog_reset
`default_nettype wire
